/* pkg/asr_regs.svh */
// register map, field positions and timing counts of the serial receiver
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

`define ASR_CTRL_OFF 8'h00
`define ASR_BAUD_OFF 8'h04
`define ASR_STAT_OFF 8'h08
`define ASR_DATA_OFF 8'h0c

`define ASR_CTRL_REN 0
`define ASR_CTRL_SYNC 1
`define ASR_CTRL_PORT_EN 2
`define ASR_CTRL_NINE 3
`define ASR_CTRL_POL 4
`define ASR_CTRL_RST 5'h00
`define ASR_BAUD_RST 16'h001a

`define ASR_TICK_HALF 4'h7
`define ASR_TICK_MID2 4'h8
`define ASR_TICK_VOTE 4'h9
`define ASR_TICK_LAST 4'hf
`define ASR_BITS_8 4'h8
`define ASR_BITS_9 4'h9
`define ASR_FIFO_DEPTH 2'h2

`define ASR_RESP_OK 2'h0
`define ASR_RESP_ERR 2'h2

`endif

/* pkg/asr_pkg.sv */
// types shared by the serial receiver modules
`default_nettype none
package asr_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_start = 2'h1,
        st_data = 2'h3,
        st_stop = 2'h2
    } asr_state_t;
    // bit 9 framing error, bits 8:0 character
    typedef logic [9:0] asr_char_t;
endpackage : asr_pkg
`default_nettype wire

/* pkg/asr_link_if.sv */
// link between receiver core, baud divider and receive fifo
`timescale 1ns/1ns
`default_nettype none
interface asr_link_if;
    import asr_pkg::*;
    logic tick;
    logic baud_run;
    logic [15:0] baud_div;
    logic push;
    asr_char_t push_data;
    logic pop;
    asr_char_t head;
    logic [1:0] count;
    modport core(input tick, head, count, output baud_run, baud_div, push, push_data, pop);
    modport baud(input baud_run, baud_div, output tick);
    modport fifo(input push, push_data, pop, output head, count);
endinterface : asr_link_if
`default_nettype wire

/* core/asr_baud.sv */
// oversampling tick divider
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.svh"
module asr_baud (
    input wire logic aclk,
    input wire logic aresetn,
    asr_link_if.baud lk
);
    import asr_pkg::*;

    logic [15:0] cnt;

    // one tick every baud_div+1 clocks; sixteen ticks per bit
    always_ff @(posedge aclk) begin
        if (!aresetn || !lk.baud_run) begin
            cnt <= 16'h0000;
            lk.tick <= 1'b0;
        end else if (cnt >= lk.baud_div) begin
            cnt <= 16'h0000;
            lk.tick <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            lk.tick <= 1'b0;
        end
    end

    AST_TICK_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
        lk.tick && lk.baud_div != 16'h0000 |=> !lk.tick)
        else $error("baud tick repeated on consecutive clocks");
    AST_TICK_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
        !lk.baud_run |=> !lk.tick)
        else $error("baud tick while divider stopped");
endmodule : asr_baud
`default_nettype wire

/* core/asr_fifo.sv */
// two-character receive fifo
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.svh"
module asr_fifo (
    input wire logic aclk,
    input wire logic aresetn,
    asr_link_if.fifo lk
);
    import asr_pkg::*;

    asr_char_t mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic do_push;
    logic do_pop;

    assign do_push = lk.push && (lk.count != `ASR_FIFO_DEPTH || lk.pop);
    assign do_pop = lk.pop && lk.count != 2'h0;
    assign lk.head = mem[rd_ptr];

    always_ff @(posedge aclk) begin
        if (do_push) begin
            mem[wr_ptr] <= lk.push_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            lk.count <= 2'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= !wr_ptr;
            end
            if (do_pop) begin
                rd_ptr <= !rd_ptr;
            end
            lk.count <= lk.count + {1'b0, do_push} - {1'b0, do_pop};
        end
    end

    AST_FIFO_PUSH: assert property (@(posedge aclk) disable iff (!aresetn)
        lk.push && !lk.pop && lk.count < `ASR_FIFO_DEPTH |=> lk.count == $past(lk.count) + 2'h1)
        else $error("pushed character not counted");
    AST_FIFO_POP: assert property (@(posedge aclk) disable iff (!aresetn)
        lk.pop && !lk.push && lk.count != 2'h0 |=> lk.count == $past(lk.count) - 2'h1)
        else $error("read character not removed");
    COV_FIFO_FULL: cover property (@(posedge aclk) disable iff (!aresetn) lk.count == `ASR_FIFO_DEPTH);
endmodule : asr_fifo
`default_nettype wire

/* core/asr_rx.sv */
// asynchronous serial receiver with axi4-lite register slave
//
// How it works
// - receiver runs only with receive enable 1, sync select 0, port enable 1.
// - line sampled at sixteen ticks per bit; shift register moves once per bit.
// - idle receiver starts a character only on a falling edge.
// - half a bit after the edge the start bit must still read zero.
// - a start bit high at its centre is dropped silently; search resumes.
// - each later bit centre is one bit apart, voted by majority, shifted in.
// - eight or nine data bits selectable, exactly that many collected.
// - one more bit time after data, stop bit sampled, expected one.
// - stop bit zero marks framing error for that character, else cleared.
// - finished character moves at once into a two-entry fifo.
// - two characters held while a third shifts in.
// - every fifo push sets the receive interrupt flag.
// - data register read returns the oldest character and removes it.
// - shift register and fifo storage reachable only through the data register, and the oldest entry's framing bit through status.
// - after overrun no character is accepted until overrun is cleared.
// - polarity bit zero: high line idle, high level is one.
// - polarity bit one inverts data: low idle, low is one.
// - polarity inversion applies only in asynchronous mode.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.svh"
module asr_rx (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_receive_pin,
    output logic receive_interrupt_flag
);
    import asr_pkg::*;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    asr_link_if lk ();

    logic [4:0] ctrl;
    logic [15:0] baud_div;
    logic ovr;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_wr;
    logic ar_take;
    logic rx_en;
    logic line;
    logic line_q;
    asr_state_t state;
    logic [3:0] tick_cnt;
    logic [3:0] bit_cnt;
    logic [8:0] receive_shift_register;
    logic [1:0] votes;
    logic vote_now;
    logic stop_bit;
    logic fifo_full;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction : maj3

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = a == `ASR_CTRL_OFF || a == `ASR_BAUD_OFF || a == `ASR_STAT_OFF || a == `ASR_DATA_OFF;
    endfunction : reg_hit

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        if (a == `ASR_CTRL_OFF) begin
            rd_word = {27'h0, ctrl};
        end else if (a == `ASR_BAUD_OFF) begin
            rd_word = {16'h0, baud_div};
        end else if (a == `ASR_STAT_OFF) begin
            rd_word = {26'h0, state != st_idle, lk.count, lk.head[9] && lk.count != 2'h0, ovr,
                receive_interrupt_flag};
        end else if (a == `ASR_DATA_OFF && lk.count != 2'h0) begin
            rd_word = {22'h0, lk.head};
        end else begin
            rd_word = 32'h0;
        end
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////////////
    // submodules
    asr_baud u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .lk(lk.baud)
    );

    asr_fifo u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .lk(lk.fifo)
    );

    assign lk.baud_div = baud_div;
    assign lk.baud_run = rx_en;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    assign do_wr = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
        end else begin
            if (do_wr) begin
                aw_held <= 1'b0;
            end
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else begin
            if (do_wr) begin
                w_held <= 1'b0;
            end
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ASR_RESP_OK;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_hit(aw_addr) ? `ASR_RESP_OK : `ASR_RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control and divider; status and data are read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `ASR_CTRL_RST;
            baud_div <= `ASR_BAUD_RST;
        end else if (do_wr && aw_addr == `ASR_CTRL_OFF) begin
            if (w_strb[0]) begin
                ctrl <= w_data[4:0];
            end
        end else if (do_wr && aw_addr == `ASR_BAUD_OFF) begin
            if (w_strb[0]) begin
                baud_div[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                baud_div[15:8] <= w_data[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign lk.pop = ar_take && s_axi_araddr == `ASR_DATA_OFF && lk.count != 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ASR_RESP_OK;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word(s_axi_araddr);
            s_axi_rresp <= reg_hit(s_axi_araddr) ? `ASR_RESP_OK : `ASR_RESP_ERR;
        end else begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line conditioning
    assign rx_en = ctrl[`ASR_CTRL_REN] && !ctrl[`ASR_CTRL_SYNC] && ctrl[`ASR_CTRL_PORT_EN];
    // inversion only when asynchronous
    assign line = serial_receive_pin ^ (ctrl[`ASR_CTRL_POL] && !ctrl[`ASR_CTRL_SYNC]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_q <= 1'b1;
        end else begin
            line_q <= line;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // character receiver
    assign vote_now = lk.tick && tick_cnt == `ASR_TICK_VOTE;
    assign stop_bit = maj3(votes[0], votes[1], line);
    assign fifo_full = lk.count == `ASR_FIFO_DEPTH && !lk.pop;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= st_idle;
            tick_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            receive_shift_register <= 9'h000;
            votes <= 2'h0;
        end else if (!rx_en) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (!ovr && line_q && !line) begin
                        state <= st_start;
                        tick_cnt <= 4'h0;
                    end
                end
                st_start: begin
                    if (lk.tick) begin
                        tick_cnt <= tick_cnt + 4'h1;
                        if (tick_cnt == `ASR_TICK_HALF && line) begin
                            state <= st_idle;
                        end else if (tick_cnt == `ASR_TICK_LAST) begin
                            state <= st_data;
                            bit_cnt <= 4'h0;
                        end
                    end
                end
                st_data: begin
                    if (lk.tick) begin
                        tick_cnt <= tick_cnt + 4'h1;
                        if (tick_cnt == `ASR_TICK_HALF) begin
                            votes[0] <= line;
                        end
                        if (tick_cnt == `ASR_TICK_MID2) begin
                            votes[1] <= line;
                        end
                        if (vote_now) begin
                            receive_shift_register <= {maj3(votes[0], votes[1], line),
                                receive_shift_register[8:1]};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (tick_cnt == `ASR_TICK_LAST &&
                            bit_cnt == (ctrl[`ASR_CTRL_NINE] ? `ASR_BITS_9 : `ASR_BITS_8)) begin
                            state <= st_stop;
                        end
                    end
                end
                st_stop: begin
                    if (lk.tick) begin
                        tick_cnt <= tick_cnt + 4'h1;
                        if (tick_cnt == `ASR_TICK_HALF) begin
                            votes[0] <= line;
                        end
                        if (tick_cnt == `ASR_TICK_MID2) begin
                            votes[1] <= line;
                        end
                        if (vote_now) begin
                            state <= st_idle;
                        end
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fifo push, overrun and flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lk.push <= 1'b0;
            lk.push_data <= 10'h000;
        end else begin
            lk.push <= rx_en && state == st_stop && vote_now && !fifo_full;
            lk.push_data <= {!stop_bit,
                ctrl[`ASR_CTRL_NINE] ? receive_shift_register : {1'b0, receive_shift_register[8:1]}};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovr <= 1'b0;
        end else if (rx_en && state == st_stop && vote_now && fifo_full) begin
            ovr <= 1'b1;
        end else if (!ctrl[`ASR_CTRL_REN]) begin
            ovr <= 1'b0;
        end
    end

    // set wins over the clear by the last read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            receive_interrupt_flag <= 1'b0;
        end else if (lk.push) begin
            receive_interrupt_flag <= 1'b1;
        end else if (lk.pop && lk.count == 2'h1) begin
            receive_interrupt_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_DISABLED_IDLE: assert property (!rx_en |=> state == st_idle)
        else $error("receiver active while disabled");
    AST_EDGE_START: assert property (rx_en && state == st_idle && !ovr && line_q && !line |=> state == st_start)
        else $error("falling edge did not start a character");
    AST_START_ABORT: assert property (rx_en && state == st_start && lk.tick
        && tick_cnt == `ASR_TICK_HALF && line |=> state == st_idle && !lk.push)
        else $error("false start bit not abandoned");
    AST_BIT_COUNT: assert property ($rose(state == st_stop) |->
        bit_cnt == (ctrl[`ASR_CTRL_NINE] ? `ASR_BITS_9 : `ASR_BITS_8))
        else $error("wrong number of data bits before stop");
    AST_FRAME_ERR: assert property (rx_en && state == st_stop && vote_now && !fifo_full
        |=> lk.push && lk.push_data[9] == !$past(stop_bit))
        else $error("framing error not tied to stop bit");
    AST_PUSH_FLAG: assert property (lk.push |=> receive_interrupt_flag)
        else $error("push did not set receive flag");
    AST_OVERRUN: assert property (rx_en && state == st_stop && vote_now && fifo_full |=> ovr && !lk.push)
        else $error("overrun not flagged");
    AST_OVR_BLOCK: assert property (ovr && state == st_idle |=> state == st_idle)
        else $error("character started during overrun");

    COV_CHAR: cover property (lk.push && !lk.push_data[9]);
    COV_FERR: cover property (lk.push && lk.push_data[9]);
    COV_OVR: cover property ($rose(ovr));
    COV_ABORT: cover property (state == st_start ##1 state == st_idle);
endmodule : asr_rx
`default_nettype wire

/* verification/asr_tx_model.sv */
// remote asynchronous serial transmitter driving the receive pin
`timescale 1ns/1ns
`default_nettype none
module asr_tx_model (
    input wire logic aclk,
    output logic line
);
    logic pol = 1'b0;
    initial begin
        line = 1'b1;
    end
    // idle level follows the polarity the receiver is set to
    task automatic set_pol(input logic p);
        @(posedge aclk);
        pol = p;
        line <= ~p;
    endtask : set_pol
    // start bit, data lsb first, one stop bit; each bit lasts bclk clocks
    task automatic send(input logic [8:0] d, input int nbits, input logic stop, input int bclk);
        logic b;
        for (int i = 0; i < nbits + 2; i++) begin
            @(posedge aclk);
            b = (i == 0) ? 1'b0 : (i > nbits) ? stop : d[i - 1];
            line <= b ^ pol;
            repeat (bclk - 1) @(posedge aclk);
        end
        @(posedge aclk);
        line <= ~pol;
    endtask : send
    // low pulse far shorter than half a bit
    task automatic glitch(input int n);
        @(posedge aclk);
        line <= pol;
        repeat (n) @(posedge aclk);
        line <= ~pol;
    endtask : glitch
endmodule : asr_tx_model
`default_nettype wire

/* verification/async_serial_receiver_bench.sv */
// self-checking bench of the asynchronous serial receiver
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.svh"
module async_serial_receiver_bench;
    import asr_pkg::*;
    localparam int LIMIT = 60000;
    localparam logic [31:0] REN = 32'h1 << `ASR_CTRL_REN;
    localparam logic [31:0] PORT_EN = 32'h1 << `ASR_CTRL_PORT_EN;
    localparam logic [31:0] ON = REN | PORT_EN;
    localparam logic [31:0] NINE = ON | (32'h1 << `ASR_CTRL_NINE);
    localparam logic [31:0] POL = 32'h1 << `ASR_CTRL_POL;
    localparam logic [31:0] SYNC = 32'h1 << `ASR_CTRL_SYNC;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic serial_receive_pin;
    logic receive_interrupt_flag;
    logic [1:0] resp;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    asr_rx dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .serial_receive_pin(serial_receive_pin), .receive_interrupt_flag(receive_interrupt_flag));
    asr_tx_model tx_u (.aclk(aclk), .line(serial_receive_pin));
    initial begin
        forever #10 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string name);
        logic ar_done;
        ar_done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            if (!ar_done && s_axi_arready === 1'b1) begin
                ar_done = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        check(name, s_axi_rdata, exp);
        check({name, " resp"}, {30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
    endtask : chk_rd
    task automatic rx_wait;
        repeat (4) @(posedge aclk);
    endtask : rx_wait
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check("flag", {31'h0, receive_interrupt_flag}, 32'h0);
        chk_rd(`ASR_CTRL_OFF, 32'h0, `ASR_RESP_OK, "ctrl");
        chk_rd(`ASR_BAUD_OFF, {16'h0, `ASR_BAUD_RST}, `ASR_RESP_OK, "baud");
        chk_rd(`ASR_STAT_OFF, 32'h0, `ASR_RESP_OK, "status");
        chk_rd(8'h10, 32'h0, `ASR_RESP_ERR, "unmapped");
        wr(8'h10, 32'hffffffff, resp);
        check("unmapped bresp", {30'h0, resp}, {30'h0, `ASR_RESP_ERR});
        wr(`ASR_DATA_OFF, 32'h1ff, resp);
        chk_rd(`ASR_STAT_OFF, 32'h0, `ASR_RESP_OK, "status after data write");
        $display("test reset done");
    endtask : t_reset
    task automatic t_gate;
        logic [31:0] cfg [3];
        cfg = '{ON | SYNC, REN, PORT_EN};
        wr(`ASR_BAUD_OFF, 32'h0, resp);
        for (int i = 0; i < 3; i++) begin
            wr(`ASR_CTRL_OFF, cfg[i], resp);
            tx_u.send(9'h055, 8, 1'b1, 16);
            rx_wait();
            chk_rd(`ASR_STAT_OFF, 32'h0, `ASR_RESP_OK, "status gated");
        end
        $display("test enable gating done");
    endtask : t_gate
    task automatic t_basic;
        wr(`ASR_CTRL_OFF, ON, resp);
        tx_u.send(9'h0a5, 8, 1'b1, 16);
        rx_wait();
        check("flag set", {31'h0, receive_interrupt_flag}, 32'h1);
        chk_rd(`ASR_STAT_OFF, 32'h9, `ASR_RESP_OK, "status one");
        chk_rd(`ASR_DATA_OFF, 32'h0a5, `ASR_RESP_OK, "data");
        check("flag clear", {31'h0, receive_interrupt_flag}, 32'h0);
        chk_rd(`ASR_DATA_OFF, 32'h0, `ASR_RESP_OK, "data empty");
        $display("test basic done");
    endtask : t_basic
    task automatic t_nine;
        wr(`ASR_CTRL_OFF, NINE, resp);
        tx_u.send(9'h1c3, 9, 1'b1, 16);
        tx_u.send(9'h0a6, 9, 1'b1, 16);
        rx_wait();
        chk_rd(`ASR_DATA_OFF, 32'h1c3, `ASR_RESP_OK, "nine first");
        chk_rd(`ASR_DATA_OFF, 32'h0a6, `ASR_RESP_OK, "nine second");
        $display("test nine bits done");
    endtask : t_nine
    task automatic t_frame;
        wr(`ASR_CTRL_OFF, ON, resp);
        tx_u.send(9'h03c, 8, 1'b0, 16);
        rx_wait();
        chk_rd(`ASR_STAT_OFF, 32'hd, `ASR_RESP_OK, "status framing");
        chk_rd(`ASR_DATA_OFF, 32'h23c, `ASR_RESP_OK, "data framing");
        tx_u.send(9'h03c, 8, 1'b1, 16);
        rx_wait();
        chk_rd(`ASR_DATA_OFF, 32'h03c, `ASR_RESP_OK, "data good stop");
        $display("test framing done");
    endtask : t_frame
    task automatic t_glitch;
        tx_u.glitch(4);
        repeat (40) @(posedge aclk);
        chk_rd(`ASR_STAT_OFF, 32'h0, `ASR_RESP_OK, "status glitch");
        tx_u.send(9'h081, 8, 1'b1, 16);
        rx_wait();
        chk_rd(`ASR_DATA_OFF, 32'h081, `ASR_RESP_OK, "data after glitch");
        $display("test false start done");
    endtask : t_glitch
    task automatic t_overrun;
        tx_u.send(9'h011, 8, 1'b1, 16);
        tx_u.send(9'h022, 8, 1'b1, 16);
        tx_u.send(9'h033, 8, 1'b1, 16);
        rx_wait();
        chk_rd(`ASR_STAT_OFF, 32'h13, `ASR_RESP_OK, "status full");
        chk_rd(`ASR_DATA_OFF, 32'h011, `ASR_RESP_OK, "oldest");
        chk_rd(`ASR_DATA_OFF, 32'h022, `ASR_RESP_OK, "second");
        tx_u.send(9'h066, 8, 1'b1, 16);
        rx_wait();
        chk_rd(`ASR_STAT_OFF, 32'h2, `ASR_RESP_OK, "status blocked");
        wr(`ASR_CTRL_OFF, 32'h0, resp);
        wr(`ASR_CTRL_OFF, ON, resp);
        chk_rd(`ASR_STAT_OFF, 32'h0, `ASR_RESP_OK, "status cleared");
        tx_u.send(9'h055, 8, 1'b1, 16);
        rx_wait();
        chk_rd(`ASR_DATA_OFF, 32'h055, `ASR_RESP_OK, "data after clear");
        $display("test overrun done");
    endtask : t_overrun
    task automatic t_pol;
        wr(`ASR_CTRL_OFF, POL, resp);
        tx_u.set_pol(1'b1);
        wr(`ASR_CTRL_OFF, ON | POL, resp);
        tx_u.send(9'h03c, 8, 1'b1, 16);
        rx_wait();
        chk_rd(`ASR_DATA_OFF, 32'h03c, `ASR_RESP_OK, "data inverted");
        wr(`ASR_CTRL_OFF, 32'h0, resp);
        tx_u.set_pol(1'b0);
        $display("test polarity done");
    endtask : t_pol
    task automatic t_baud;
        wr(`ASR_BAUD_OFF, 32'h1, resp);
        wr(`ASR_CTRL_OFF, ON, resp);
        tx_u.send(9'h096, 8, 1'b1, 32);
        rx_wait();
        chk_rd(`ASR_DATA_OFF, 32'h096, `ASR_RESP_OK, "data slow baud");
        $display("test baud divider done");
    endtask : t_baud
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge aclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            $display("Error timeout expected done seen hang");
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_gate();
        t_basic();
        t_nine();
        t_frame();
        t_glitch();
        t_overrun();
        t_pol();
        t_baud();
        tally_and_finish();
    end
endmodule : async_serial_receiver_bench
`default_nettype wire
